// *** output_fault_diag_regs.svh ***
// offsets, field positions, reset values and character codes of the output fault diagnostic block
`ifndef OUTPUT_FAULT_DIAG_REGS_SVH
`define OUTPUT_FAULT_DIAG_REGS_SVH

// ****************************************************************
// holding register map
// ****************************************************************
`define FLAGS_REG_OFFSET 16'h9D73
`define FLAGS_REG_RESET 16'h0000
`define FLAGS_GROUP_LSB 0
`define FLAGS_GROUP_WIDTH 8

// ****************************************************************
// ascii query and answer characters
// ****************************************************************
`define CHAR_QUERY_START 8'h24
`define CHAR_ZERO 8'h30
`define CHAR_ONE 8'h31
`define CHAR_SEVEN 8'h37
`define CHAR_CR 8'h0D
`define CHAR_ANSWER_START 8'h21
`define QUERY_LENGTH 3'h5
`define ANSWER_PREFIX_LENGTH 4'h3

`endif

// *** fault_diag_pkg.sv ***
// types shared by the output fault diagnostic design
package fault_diag_pkg;

    // ****************************************************************
    // output stage variants
    // ****************************************************************
    typedef enum logic [1:0]
    {
        SINK_THREE_GROUP = 2'b00,
        SINK_ONE_GROUP = 2'b01,
        SOURCE_EIGHT_GROUP = 2'b10
    } variant_t;

    // answer sender states
    typedef enum logic [0:0]
    {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_t;

    // number of diagnostic groups a variant reports
    function automatic logic [3:0] group_count(input variant_t v);
        unique case (v)
            SINK_THREE_GROUP: group_count = 4'h3;
            SINK_ONE_GROUP: group_count = 4'h1;
            SOURCE_EIGHT_GROUP: group_count = 4'h8;
            default: group_count = 4'h1;
        endcase
    endfunction

endpackage

// *** ascii_diag_responder.sv ***
// ascii query parser and flag answer sender
`timescale 1ns/10ps
`default_nettype none
`include "output_fault_diag_regs.svh"

module ascii_diag_responder
    import fault_diag_pkg::*;
#(
    parameter variant_t VARIANT = SINK_THREE_GROUP
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [7:0] flags_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic tx_ready_in,
    output logic tx_valid_out,
    output logic [7:0] tx_byte_out,
    output logic busy_out
);

    localparam logic [3:0] GROUPS = group_count(VARIANT);
    localparam logic [3:0] ANSWER_LEN = `ANSWER_PREFIX_LENGTH + GROUPS + 4'h1;

    // ****************************************************************
    // character selection
    // ****************************************************************
    // expected query character at a parse position
    function automatic logic [7:0] query_char(input logic [2:0] idx);
        unique case (idx)
            3'h0: query_char = `CHAR_QUERY_START;
            3'h1: query_char = `CHAR_ZERO;
            3'h2: query_char = `CHAR_ONE;
            3'h3: query_char = `CHAR_SEVEN;
            default: query_char = `CHAR_CR;
        endcase
    endfunction

    // answer character at a send position, highest group first
    function automatic logic [7:0] answer_char(input logic [3:0] idx, input logic [7:0] flags);
        logic [3:0] grp;
        grp = 4'h0;
        if (idx == 4'h0)
            answer_char = `CHAR_ANSWER_START;
        else if (idx == 4'h1)
            answer_char = `CHAR_ZERO;
        else if (idx == 4'h2)
            answer_char = `CHAR_ONE;
        else if (idx < ANSWER_LEN - 4'h1)
        begin
            grp = GROUPS - 4'h1 - (idx - `ANSWER_PREFIX_LENGTH);
            answer_char = flags[grp[2:0]] ? `CHAR_ONE : `CHAR_ZERO;
        end
        else
            answer_char = `CHAR_CR;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [2:0] parse_q, parse_d; // characters of the query matched so far
    tx_state_t tx_state_q, tx_state_d; // sending an answer or not
    logic [3:0] tx_idx_q, tx_idx_d; // position of the character on the port
    logic [7:0] snap_q, snap_d; // flags frozen for one whole answer
    logic tx_valid_q, tx_valid_d;
    logic [7:0] tx_byte_q, tx_byte_d;

    // next values: parse while idle, stream answer while sending
    always_comb
    begin
        parse_d = parse_q;
        tx_state_d = tx_state_q;
        tx_idx_d = tx_idx_q;
        snap_d = snap_q;
        tx_valid_d = tx_valid_q;
        tx_byte_d = tx_byte_q;
        unique case (tx_state_q)
            TX_IDLE:
            begin
                // a query byte arriving mid-answer is dropped, so only idle parses
                if (rx_valid_in)
                begin
                    if (rx_byte_in == query_char(parse_q) && parse_q == `QUERY_LENGTH - 3'h1)
                    begin
                        // full query seen: freeze flags and open the answer
                        parse_d = 3'h0;
                        snap_d = flags_in;
                        tx_state_d = TX_SEND;
                        tx_idx_d = 4'h0;
                        tx_valid_d = 1'b1;
                        tx_byte_d = answer_char(4'h0, flags_in);
                    end
                    else if (rx_byte_in == query_char(parse_q))
                        parse_d = parse_q + 3'h1;
                    else if (rx_byte_in == `CHAR_QUERY_START)
                        parse_d = 3'h1; // a fresh start character restarts the query
                    else
                        parse_d = 3'h0;
                end
            end
            TX_SEND:
            begin
                // advance only when the far side takes the character
                if (tx_ready_in)
                begin
                    if (tx_idx_q == ANSWER_LEN - 4'h1)
                    begin
                        tx_state_d = TX_IDLE;
                        tx_valid_d = 1'b0;
                    end
                    else
                    begin
                        tx_idx_d = tx_idx_q + 4'h1;
                        tx_byte_d = answer_char(tx_idx_q + 4'h1, snap_q);
                    end
                end
            end
        endcase
    end

    // register the parser and sender
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            parse_q <= 3'h0;
            tx_state_q <= TX_IDLE;
            tx_idx_q <= 4'h0;
            snap_q <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_byte_q <= 8'h00;
        end
        else if (ce_in)
        begin
            parse_q <= parse_d;
            tx_state_q <= tx_state_d;
            tx_idx_q <= tx_idx_d;
            snap_q <= snap_d;
            tx_valid_q <= tx_valid_d;
            tx_byte_q <= tx_byte_d;
        end
    end

    assign tx_valid_out = tx_valid_q;
    assign tx_byte_out = tx_byte_q;
    assign busy_out = tx_state_q; // one-bit state doubles as the busy level

endmodule
`default_nettype wire

// *** output_fault_diagnostic_status.sv ***
// output fault diagnostic status: fault sensing, group flags, holding register and ascii query
`timescale 1ns/10ps
`default_nettype none
`include "output_fault_diag_regs.svh"

module output_fault_diagnostic_status
    import fault_diag_pkg::*;
#(
    parameter variant_t VARIANT = SINK_THREE_GROUP,
    parameter int CHANNELS = 8
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [CHANNELS-1:0] channel_active_in,
    input wire logic [CHANNELS-1:0] open_load_in,
    input wire logic [CHANNELS-1:0] short_ground_in,
    input wire logic [CHANNELS-1:0] over_current_in,
    input wire logic [15:0] holding_addr_in,
    input wire logic holding_rd_in,
    input wire logic holding_wr_in,
    input wire logic [15:0] holding_wdata_in,
    output logic [15:0] holding_rdata_out,
    output logic holding_ack_out,
    output logic holding_exception_out,
    input wire logic query_valid_in,
    input wire logic [7:0] query_byte_in,
    input wire logic answer_ready_in,
    output logic answer_valid_out,
    output logic [7:0] answer_byte_out,
    output logic query_busy_out,
    output logic [7:0] group_flags_out,
    output logic [CHANNELS-1:0] channel_fault_out
);

    // ****************************************************************
    // fault pin synchronisers
    // ****************************************************************
    // the three sense lines of each channel come from the analog output stage,
    // so each passes three flip-flops; a change counts once stages two and three agree
    logic [3*CHANNELS-1:0] pins_raw;
    logic [3*CHANNELS-1:0] sync1_q, sync2_q, sync3_q; // stage one feeds stage two only
    logic [3*CHANNELS-1:0] stable_q, stable_d; // debounced sense levels

    assign pins_raw = {over_current_in, short_ground_in, open_load_in};

    // accept a bit only where the last two stages agree
    always_comb
    begin
        stable_d = stable_q;
        for (int i = 0; i < 3 * CHANNELS; i++)
        begin
            if (sync2_q[i] == sync3_q[i])
                stable_d[i] = sync3_q[i];
        end
    end

    // register synchroniser chain and accepted levels
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            stable_q <= '0;
        end
        else if (ce_in)
        begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            stable_q <= stable_d;
        end
    end

    // ****************************************************************
    // per channel fault and group flags
    // ****************************************************************
    logic [CHANNELS-1:0] open_s, short_s, over_s;
    logic [CHANNELS-1:0] fault_d, fault_q; // live fault per channel
    logic [7:0] group_d, group_q; // group flags, 1 means abnormal

    assign open_s = stable_q[CHANNELS-1:0];
    assign short_s = stable_q[2*CHANNELS-1:CHANNELS];
    assign over_s = stable_q[3*CHANNELS-1:2*CHANNELS];

    // fault classification depends on drive state and output stage type
    always_comb
    begin
        fault_d = '0;
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (VARIANT == SOURCE_EIGHT_GROUP)
                fault_d[c] = channel_active_in[c] & (short_s[c] | over_s[c]);
            else if (channel_active_in[c])
                fault_d[c] = over_s[c];
            else
                fault_d[c] = open_s[c] | short_s[c];
        end
    end

    // group mapping; recomputed every cycle so a cleared fault clears its flag
    always_comb
    begin
        group_d = 8'h00;
        unique case (VARIANT)
            SINK_THREE_GROUP:
            begin
                // pairs 0-1, 2-3, 4-5; either or both faulty gives 1
                group_d[0] = fault_q[0] | fault_q[1];
                group_d[1] = fault_q[2] | fault_q[3];
                group_d[2] = fault_q[4] | fault_q[5];
            end
            SINK_ONE_GROUP:
                group_d[0] = fault_q[0] | fault_q[1];
            SOURCE_EIGHT_GROUP:
            begin
                // one channel per group
                for (int g = 0; g < 8; g++)
                    group_d[g] = fault_q[g];
            end
            default: group_d = 8'h00;
        endcase
    end

    // register faults and flags
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            fault_q <= '0;
            group_q <= 8'h00;
        end
        else if (ce_in)
        begin
            fault_q <= fault_d;
            group_q <= group_d;
        end
    end

    // ****************************************************************
    // holding register access
    // ****************************************************************
    logic [15:0] rdata_d, rdata_q;
    logic ack_d, ack_q;
    logic exc_d, exc_q;
    logic hit;

    assign hit = (holding_addr_in == `FLAGS_REG_OFFSET);

    // one answer per strobe, one cycle later; the write data is never stored
    always_comb
    begin
        rdata_d = rdata_q;
        ack_d = 1'b0;
        exc_d = 1'b0;
        if (holding_rd_in || holding_wr_in)
        begin
            ack_d = 1'b1;
            exc_d = ~hit; // unmapped address answers with an exception
            if (holding_rd_in && hit)
            begin
                // flags in the low byte, group n at bit n counted from zero
                rdata_d = `FLAGS_REG_RESET;
                rdata_d[`FLAGS_GROUP_LSB +: `FLAGS_GROUP_WIDTH] = group_q;
            end
            else if (holding_rd_in)
                rdata_d = 16'h0000;
            // a write is acknowledged and dropped so the flags stay hardware-owned
        end
    end

    // register the bus answer
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rdata_q <= `FLAGS_REG_RESET;
            ack_q <= 1'b0;
            exc_q <= 1'b0;
        end
        else if (ce_in)
        begin
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            exc_q <= exc_d;
        end
    end

    // ****************************************************************
    // ascii query
    // ****************************************************************
    ascii_diag_responder #(
        .VARIANT(VARIANT)
    ) ascii_diag_responder_i (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .flags_in(group_q),
        .rx_valid_in(query_valid_in),
        .rx_byte_in(query_byte_in),
        .tx_ready_in(answer_ready_in),
        .tx_valid_out(answer_valid_out),
        .tx_byte_out(answer_byte_out),
        .busy_out(query_busy_out)
    );

    // all outputs come straight from flip-flops
    assign holding_rdata_out = rdata_q;
    assign holding_ack_out = ack_q;
    assign holding_exception_out = exc_q;
    assign group_flags_out = group_q;
    assign channel_fault_out = fault_q;

    // write data has no destination by design
    logic unused_wdata;
    assign unused_wdata = ^holding_wdata_in;

endmodule
`default_nettype wire

// *** output_fault_diagnostic_status_assertions.sv ***
// port checker of the output fault diagnostic block
`timescale 1ns/10ps
`default_nettype none
`include "output_fault_diag_regs.svh"

module fault_diag_checker
    import fault_diag_pkg::*;
#(
    parameter variant_t VARIANT = SINK_THREE_GROUP,
    parameter int CHANNELS = 8
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [CHANNELS-1:0] channel_active_in,
    input wire logic [CHANNELS-1:0] open_load_in,
    input wire logic [CHANNELS-1:0] short_ground_in,
    input wire logic [CHANNELS-1:0] over_current_in,
    input wire logic [15:0] holding_addr_in,
    input wire logic holding_rd_in,
    input wire logic holding_wr_in,
    input wire logic [15:0] holding_rdata_out,
    input wire logic holding_ack_out,
    input wire logic holding_exception_out,
    input wire logic answer_ready_in,
    input wire logic answer_valid_out,
    input wire logic [7:0] answer_byte_out,
    input wire logic query_busy_out,
    input wire logic [7:0] group_flags_out,
    input wire logic [CHANNELS-1:0] channel_fault_out
);
    // groups reported; sinks pair channels, the source maps one to one
    localparam int GROUPS = (VARIANT == SOURCE_EIGHT_GROUP) ? 8 : (VARIANT == SINK_ONE_GROUP) ? 1 : 3;
    logic [7:0] grp_any; // some member channel of the group is faulty
    // ****
    // group reference
    // ****
    always_comb
    begin
        grp_any = 8'h00;
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (((GROUPS == 8) ? c : c / 2) < GROUPS)
            begin
                grp_any[(GROUPS == 8) ? c : c / 2] = grp_any[(GROUPS == 8) ? c : c / 2] | channel_fault_out[c];
            end
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    a_flag_follows: assert property (ce_in |=> group_flags_out == $past(grp_any))
        else $error("group flags differ from member faults");
    a_reserved_bits: assert property ((group_flags_out >> GROUPS) == 8'h00)
        else $error("reserved group bit set");
    a_ack_follows: assert property ((ce_in && (holding_rd_in || holding_wr_in)) |=> holding_ack_out)
        else $error("no acknowledge after request");
    a_unmapped_exc: assert property (
        (ce_in && (holding_rd_in || holding_wr_in) && holding_addr_in != `FLAGS_REG_OFFSET) |=> holding_exception_out)
        else $error("unmapped address not refused");
    a_read_flags: assert property (
        (ce_in && holding_rd_in && holding_addr_in == `FLAGS_REG_OFFSET)
        |=> holding_rdata_out == {8'h00, $past(group_flags_out)})
        else $error("read data not the group flags");
    a_write_ignored: assert property ((holding_wr_in && !holding_rd_in) |=> $stable(holding_rdata_out))
        else $error("write altered read data");
    a_answer_prefix: assert property ($rose(answer_valid_out) |-> answer_byte_out == 8'h21)
        else $error("answer does not open with prefix");
    a_answer_hold: assert property (
        (answer_valid_out && !answer_ready_in) |=> answer_valid_out && $stable(answer_byte_out))
        else $error("answer byte dropped before taken");
    a_busy_covers: assert property (answer_valid_out |-> query_busy_out)
        else $error("answer byte offered while not busy");
    // per channel classification, six stable cycles cover the sync latency
    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_ch
        if (VARIANT != SOURCE_EIGHT_GROUP)
        begin : g_sink
            a_sink_off_fault: assert property (
                (ce_in && !channel_active_in[c] && (open_load_in[c] | short_ground_in[c]))[*6] |=> channel_fault_out[c])
                else $error("off channel fault missed");
            a_sink_on_fault: assert property (
                (ce_in && channel_active_in[c] && over_current_in[c])[*6] |=> channel_fault_out[c])
                else $error("overcurrent missed");
        end
        else
        begin : g_src
            a_source_on_fault: assert property (
                (ce_in && channel_active_in[c] && (short_ground_in[c] | over_current_in[c]))[*6] |=> channel_fault_out[c])
                else $error("source fault missed");
        end
    end
endmodule

bind output_fault_diagnostic_status fault_diag_checker #(.VARIANT(VARIANT), .CHANNELS(CHANNELS)) fault_diag_checker_i (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .channel_active_in(channel_active_in),
    .open_load_in(open_load_in), .short_ground_in(short_ground_in), .over_current_in(over_current_in),
    .holding_addr_in(holding_addr_in), .holding_rd_in(holding_rd_in), .holding_wr_in(holding_wr_in),
    .holding_rdata_out(holding_rdata_out), .holding_ack_out(holding_ack_out),
    .holding_exception_out(holding_exception_out), .answer_ready_in(answer_ready_in),
    .answer_valid_out(answer_valid_out), .answer_byte_out(answer_byte_out), .query_busy_out(query_busy_out),
    .group_flags_out(group_flags_out), .channel_fault_out(channel_fault_out));
`default_nettype wire

// *** query_host.sv ***
// host model that sends the ascii status query and takes the answer
`timescale 1ns/10ps
`default_nettype none

module query_host
(
    input wire logic clk_in,
    input wire logic answer_valid_in,
    input wire logic [7:0] answer_byte_in,
    output logic query_valid_out,
    output logic [7:0] query_byte_out,
    output logic answer_ready_out
);
    logic [7:0] cmd [5] = '{8'h24, 8'h30, 8'h31, 8'h37, 8'h0D}; // dollar, 0, 1, 7, carriage return
    logic [7:0] got [12]; // answer bytes in arrival order
    int n = 0; // answer bytes taken
    initial
    begin
        query_valid_out = 1'b0;
        query_byte_out = 8'h00;
        answer_ready_out = 1'b0;
    end
    // ****
    // one query; slow stalls every other cycle
    // ****
    task automatic run(input logic slow);
        n = 0;
        for (int k = 0; k < 5; k++)
        begin
            query_valid_out <= 1'b1;
            query_byte_out <= cmd[k];
            @(posedge clk_in);
        end
        query_valid_out <= 1'b0;
        query_byte_out <= ~query_byte_out; // a released line must not keep the last byte
        // bounded: a taken carriage return ends the wait, and without one it stops after 40 cycles
        for (int t = 0; t < 40 && (n == 0 || got[n - 1] !== 8'h0D); t++)
        begin
            answer_ready_out <= !(slow && t[0]);
            @(posedge clk_in);
            if (answer_valid_in && answer_ready_out && n < 12)
            begin
                got[n] = answer_byte_in;
                n++;
            end
        end
        answer_ready_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb_output_fault_diagnostic_status.sv ***
// self-checking bench of the output fault diagnostic block
`timescale 1ns/10ps
`default_nettype none
`include "output_fault_diag_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_output_fault_diagnostic_status;
    typedef struct packed {logic [7:0] act, opn, shg, ovc; logic [2:0] flg; logic [7:0] src;} row_t;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ce_in = 1'b1; // low only in the freeze test
    logic [7:0] channel_active_in = 8'h00;
    logic [7:0] open_load_in = 8'h00;
    logic [7:0] short_ground_in = 8'h00;
    logic [7:0] over_current_in = 8'h00;
    logic [15:0] holding_addr_in = 16'h0000;
    logic holding_rd_in = 1'b0;
    logic holding_wr_in = 1'b0;
    logic [15:0] holding_wdata_in = 16'h0000;
    logic [15:0] holding_rdata_out, rdata;
    logic holding_ack_out, holding_exception_out, query_valid_in, answer_ready_in, answer_valid_out, query_busy_out;
    logic [7:0] query_byte_in, answer_byte_out, group_flags_out, channel_fault_out, src_flags_out;
    logic [7:0] exp_ans [7] = '{8'h21, 8'h30, 8'h31, 8'h31, 8'h31, 8'h30, 8'h0D}; // answer for flags 110
    int n_errors = 0;
    int checks = 0;
    // ****
    // pin states and the sink pair flags they give
    // ****
    row_t rows [9] = '{
        '{8'h00, 8'h00, 8'h00, 8'h00, 3'b000, 8'h00}, // quiet
        '{8'h00, 8'h00, 8'h04, 8'h00, 3'b010, 8'h00}, // ch2 off, ground short
        '{8'h00, 8'h02, 8'h00, 8'h00, 3'b001, 8'h00}, // ch1 off, open load; group 1 clears
        '{8'h10, 8'h00, 8'h00, 8'h10, 3'b100, 8'h10}, // ch4 on, overcurrent
        '{8'h10, 8'h10, 8'h00, 8'h00, 3'b000, 8'h00}, // ch4 on, open load is no fault
        '{8'h01, 8'h00, 8'h01, 8'h00, 3'b000, 8'h01}, // ch0 on, ground short; source flags it
        '{8'h00, 8'h0C, 8'h20, 8'h00, 3'b110, 8'h00}, // both of group 1, and ch5
        '{8'h00, 8'hC0, 8'hC0, 8'hC0, 3'b000, 8'h00}, // ch6 and ch7 in no sink group
        '{8'h01, 8'h02, 8'h00, 8'h01, 3'b001, 8'h01}  // ch0 overcurrent, ch1 open
    };
    output_fault_diagnostic_status output_fault_diagnostic_status_i (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .channel_active_in(channel_active_in),
        .open_load_in(open_load_in), .short_ground_in(short_ground_in), .over_current_in(over_current_in),
        .holding_addr_in(holding_addr_in), .holding_rd_in(holding_rd_in), .holding_wr_in(holding_wr_in),
        .holding_wdata_in(holding_wdata_in), .holding_rdata_out(holding_rdata_out),
        .holding_ack_out(holding_ack_out), .holding_exception_out(holding_exception_out),
        .query_valid_in(query_valid_in), .query_byte_in(query_byte_in), .answer_ready_in(answer_ready_in),
        .answer_valid_out(answer_valid_out), .answer_byte_out(answer_byte_out), .query_busy_out(query_busy_out),
        .group_flags_out(group_flags_out), .channel_fault_out(channel_fault_out));
    // source variant on the same pins; only its group flags are compared
    output_fault_diagnostic_status #(
        .VARIANT(fault_diag_pkg::SOURCE_EIGHT_GROUP)
    ) output_fault_diagnostic_status_src_i (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .channel_active_in(channel_active_in),
        .open_load_in(open_load_in), .short_ground_in(short_ground_in), .over_current_in(over_current_in),
        .holding_addr_in(holding_addr_in), .holding_rd_in(holding_rd_in), .holding_wr_in(holding_wr_in),
        .holding_wdata_in(holding_wdata_in), .holding_rdata_out(), .holding_ack_out(),
        .holding_exception_out(), .query_valid_in(1'b0), .query_byte_in(8'h00), .answer_ready_in(1'b0),
        .answer_valid_out(), .answer_byte_out(), .query_busy_out(),
        .group_flags_out(src_flags_out), .channel_fault_out());
    query_host query_host_i (
        .clk_in(clk_in), .answer_valid_in(answer_valid_out), .answer_byte_in(answer_byte_out),
        .query_valid_out(query_valid_in), .query_byte_out(query_byte_in), .answer_ready_out(answer_ready_in));
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic close_out();
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one register access; the answer is looked at mid-cycle, where it stands
    task automatic bus(input logic wr, input logic [15:0] addr, input logic exc, output logic [15:0] rd);
        holding_addr_in <= addr;
        holding_rd_in <= !wr;
        holding_wr_in <= wr;
        holding_wdata_in <= 16'hFFFF; // all ones must never reach the flags
        @(posedge clk_in);
        holding_rd_in <= 1'b0;
        holding_wr_in <= 1'b0;
        @(negedge clk_in);
        rd = holding_rdata_out;
        `CHK("ack", 1'b1, holding_ack_out)
        `CHK("exception", exc, holding_exception_out)
        @(posedge clk_in);
    endtask
    task automatic pins(input row_t r);
        channel_active_in <= r.act;
        open_load_in <= r.opn;
        short_ground_in <= r.shg;
        over_current_in <= r.ovc;
        repeat (10) @(posedge clk_in);
    endtask
    initial
    begin
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        foreach (rows[i])
        begin
            pins(rows[i]);
            bus(1'b0, `FLAGS_REG_OFFSET, 1'b0, rdata);
            `CHK("flags", {5'h00, rows[i].flg}, group_flags_out)
            `CHK("holding", {13'h0000, rows[i].flg}, rdata)
            `CHK("source flags", rows[i].src, src_flags_out)
        end
        pins(rows[6]);
        `CHK("channel faults", 8'h2C, channel_fault_out)
        for (int s = 0; s < 2; s++)
        begin
            query_host_i.run(s[0]);
            repeat (2) @(posedge clk_in);
            `CHK("answer length", 7, query_host_i.n)
            for (int b = 0; b < 7; b++) `CHK("answer byte", exp_ans[b], query_host_i.got[b])
            `CHK("busy after answer", 1'b0, query_busy_out)
            if (query_host_i.n != 7)
                close_out();
        end
        bus(1'b0, 16'h9D74, 1'b1, rdata);
        `CHK("unmapped read", 16'h0000, rdata)
        bus(1'b1, `FLAGS_REG_OFFSET, 1'b0, rdata);
        bus(1'b0, `FLAGS_REG_OFFSET, 1'b0, rdata);
        `CHK("after write", 16'h0006, rdata)
        // a low enable must hold the flags through a pin change
        ce_in <= 1'b0;
        pins(rows[1]);
        `CHK("frozen flags", 8'h06, group_flags_out)
        ce_in <= 1'b1;
        pins(rows[1]);
        `CHK("thawed flags", 8'h02, group_flags_out)
        pins(rows[6]);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        `CHK("flags in reset", 8'h00, group_flags_out)
        reset_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        `CHK("flags after reset", 8'h06, group_flags_out)
        close_out();
    end
endmodule
`default_nettype wire
